// ===== ast_baud_gen.sv
`timescale 1ns/1ns
`default_nettype none
module ast_baud_gen
  import ast_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic src_tick,
  input wire logic [3:0] div_shift,
  output logic tick16
);
  typedef struct packed {
    logic [AST_DIV_W-1:0] cnt;
    logic tick;
  } ast_baud_state_type;

  ast_baud_state_type s_q;
  ast_baud_state_type s_d;
  logic [AST_DIV_W:0] span;
  logic [AST_DIV_W-1:0] mask;

  // A free counter avoids a reload compare; a rate change lands within one period.
  always_comb begin
    s_d = s_q;
    span = (AST_DIV_W+1)'(1) << div_shift;
    mask = span[AST_DIV_W-1:0] - AST_DIV_W'(1);
    s_d.tick = 1'b0;
    if (src_tick) begin
      s_d.cnt = s_q.cnt + AST_DIV_W'(1);
      s_d.tick = ((s_q.cnt & mask) == mask);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick16 = s_q.tick;
endmodule : ast_baud_gen
`default_nettype wire

// ===== ast_core.sv
`timescale 1ns/1ns
`default_nettype none
module ast_core
  import ast_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire ast_cfg_type cfg,
  input wire logic xtal_clk_in,
  input wire logic rc_clk_in,
  input wire logic tx_wr,
  input wire logic [7:0] tx_data,
  input wire logic rx_rd,
  input wire logic rx_status_wr,
  output ast_status_type status,
  output logic [7:0] rx_data,
  output logic tx_empty_irq,
  output logic rx_full_irq,
  input wire logic rx_pad,
  output logic tx_pad,
  output logic tx_pad_oe
);
  ast_core_state_type s_q;
  ast_core_state_type s_d;
  ast_rx_word_type rx_word;
  ast_rx_word_type buf_word;
  logic tick16;
  logic src_tick;
  logic push;
  logic push_ready;
  logic buf_valid;
  logic buf_take;
  logic [3:0] div_shift;
  logic [2:0] rc_sel_eff;
  logic [2:0] baud_shift;
  logic [2:0] last_bit;
  logic rx_line;
  logic par_flip;

  // Reserved prescaler codes fall back to the slowest legal division.
  assign rc_sel_eff = (cfg.rc_prescaler_select > AST_RC_SEL_MAX) ?
    AST_RC_SEL_MAX : cfg.rc_prescaler_select;
  assign baud_shift = AST_BAUD_MAX - cfg.baud_select;
  // The crystal path never sees the RC prescaler.
  assign div_shift = cfg.clock_source_select ? {1'b0, baud_shift} :
    ({1'b0, rc_sel_eff} + {1'b0, baud_shift});
  assign last_bit = (cfg.word_length_select == AST_WL_8BIT) ?
    AST_LAST_BIT_8 : AST_LAST_BIT_7;
  assign par_flip = (cfg.parity_odd_even != AST_PAR_EVEN);
  assign rx_line = s_q.rx_level ^ cfg.rx_invert;

  ast_baud_gen u_baud (
    .clk(clk),
    .rst_n(rst_n),
    .src_tick(src_tick),
    .div_shift(div_shift),
    .tick16(tick16)
  );

  // Up to two completed characters wait here; a word that arrives while both entries are full is lost.
  ast_pair_buf #(
    .WIDTH($bits(ast_rx_word_type))
  ) u_rx_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(rx_word),
    .out_valid(buf_valid),
    .out_ready(!s_q.rx_full),
    .out_data(buf_word)
  );

  assign buf_take = buf_valid && !s_q.rx_full;

  always_comb begin
    s_d = s_q;
    push = 1'b0;
    rx_word = '0;
    src_tick = 1'b0;
    s_d.tx_irq = 1'b0;
    s_d.rx_irq = 1'b0;

    // Pads and oscillator inputs: a change counts once two stages agree.
    s_d.rx_sync = {s_q.rx_sync[1:0], rx_pad};
    s_d.xt_sync = {s_q.xt_sync[1:0], xtal_clk_in};
    s_d.rc_sync = {s_q.rc_sync[1:0], rc_clk_in};
    if (s_q.rx_sync[1] == s_q.rx_sync[2]) begin
      s_d.rx_level = s_q.rx_sync[2];
    end
    if (s_q.xt_sync[1] == s_q.xt_sync[2]) begin
      s_d.xt_level = s_q.xt_sync[2];
    end
    if (s_q.rc_sync[1] == s_q.rc_sync[2]) begin
      s_d.rc_level = s_q.rc_sync[2];
    end
    if (cfg.clock_source_select) begin
      src_tick = s_d.xt_level && !s_q.xt_level;
    end else begin
      src_tick = s_d.rc_level && !s_q.rc_level;
    end
    s_d.rx_prev = s_q.rx_level;

    // Receiver, sampling at sixteen ticks per bit from mid start bit.
    case (s_q.rx_st)
      AST_ST_IDLE: begin
        if ((s_q.rx_prev ^ cfg.rx_invert) && !rx_line) begin
          s_d.rx_st = AST_ST_START;
          s_d.rx_ph = '0;
        end
      end
      AST_ST_START: begin
        if (tick16) begin
          s_d.rx_ph = s_q.rx_ph + 4'h1;
          if (s_q.rx_ph == AST_MID_LAST) begin
            s_d.rx_ph = '0;
            s_d.rx_bit = '0;
            s_d.rx_par = 1'b0;
            s_d.rx_shift = '0;
            if (rx_line != AST_LINE_START) begin
              s_d.rx_st = AST_ST_IDLE;
            end else begin
              s_d.rx_st = AST_ST_DATA;
            end
          end
        end
      end
      AST_ST_DATA: begin
        if (tick16) begin
          s_d.rx_ph = s_q.rx_ph + 4'h1;
          if (s_q.rx_ph == AST_OVS_LAST) begin
            s_d.rx_shift = {rx_line, s_q.rx_shift[7:1]};
            s_d.rx_par = s_q.rx_par ^ rx_line;
            s_d.rx_bit = s_q.rx_bit + 3'h1;
            if (s_q.rx_bit == last_bit) begin
              s_d.rx_st = cfg.parity_enable ? AST_ST_PARITY : AST_ST_STOP;
              s_d.rx_par_bad = 1'b0;
            end
          end
        end
      end
      AST_ST_PARITY: begin
        if (tick16) begin
          s_d.rx_ph = s_q.rx_ph + 4'h1;
          if (s_q.rx_ph == AST_OVS_LAST) begin
            s_d.rx_par_bad = (rx_line != (s_q.rx_par ^ par_flip));
            s_d.rx_st = AST_ST_STOP;
          end
        end
      end
      AST_ST_STOP: begin
        if (tick16) begin
          s_d.rx_ph = s_q.rx_ph + 4'h1;
          if (s_q.rx_ph == AST_OVS_LAST) begin
            push = 1'b1;
            rx_word.data = (last_bit == AST_LAST_BIT_8) ? s_q.rx_shift :
              {1'b0, s_q.rx_shift[7:1]};
            rx_word.parity_err = s_q.rx_par_bad;
            rx_word.frame_err = (rx_line != AST_LINE_IDLE);
            s_d.rx_st = AST_ST_IDLE;
          end
        end
      end
      default: begin
        s_d.rx_st = AST_ST_IDLE;
      end
    endcase
    if (!cfg.receive_enable) begin
      s_d.rx_st = AST_ST_IDLE;
      push = 1'b0;
    end

    // Holding register: load from the buffer, clear on a read.
    if (rx_rd) begin
      s_d.rx_full = 1'b0;
    end
    if (buf_take) begin
      s_d.rx_full = 1'b1;
      s_d.rx_irq = 1'b1;
      s_d.rx_data = buf_word.data;
      s_d.par_err = buf_word.parity_err;
      s_d.frm_err = buf_word.frame_err;
      s_d.start_err = 1'b0;
    end
    if (s_q.rx_st == AST_ST_START && tick16 && s_q.rx_ph == AST_MID_LAST &&
        rx_line != AST_LINE_START) begin
      s_d.start_err = 1'b1;
    end
    // A status write clears overrun, but a new overrun in that cycle wins.
    if (rx_status_wr) begin
      s_d.over_err = 1'b0;
    end
    if (push && s_q.rx_full) begin
      s_d.over_err = 1'b1;
    end

    // Transmitter.
    case (s_q.tx_st)
      AST_ST_IDLE: begin
        s_d.tx_line = AST_LINE_IDLE;
        if (cfg.transmit_enable && s_q.tx_full) begin
          s_d.tx_shift = s_q.tx_hold;
          if (last_bit != AST_LAST_BIT_8) begin
            s_d.tx_shift[7] = 1'b0;
          end
          s_d.tx_par = (^s_d.tx_shift) ^ par_flip;
          s_d.tx_full = 1'b0;
          s_d.tx_irq = 1'b1;
          s_d.tx_ph = '0;
          s_d.tx_line = AST_LINE_START;
          s_d.tx_st = AST_ST_START;
        end
      end
      AST_ST_START: begin
        if (tick16) begin
          s_d.tx_ph = s_q.tx_ph + 4'h1;
          if (s_q.tx_ph == AST_OVS_LAST) begin
            s_d.tx_line = s_q.tx_shift[0];
            s_d.tx_bit = '0;
            s_d.tx_st = AST_ST_DATA;
          end
        end
      end
      AST_ST_DATA: begin
        if (tick16) begin
          s_d.tx_ph = s_q.tx_ph + 4'h1;
          if (s_q.tx_ph == AST_OVS_LAST) begin
            s_d.tx_bit = s_q.tx_bit + 3'h1;
            s_d.tx_shift = {1'b0, s_q.tx_shift[7:1]};
            s_d.tx_line = s_q.tx_shift[1];
            if (s_q.tx_bit == last_bit) begin
              s_d.tx_line = cfg.parity_enable ? s_q.tx_par : AST_LINE_IDLE;
              s_d.tx_st = cfg.parity_enable ? AST_ST_PARITY : AST_ST_STOP;
            end
          end
        end
      end
      AST_ST_PARITY: begin
        if (tick16) begin
          s_d.tx_ph = s_q.tx_ph + 4'h1;
          if (s_q.tx_ph == AST_OVS_LAST) begin
            s_d.tx_line = AST_LINE_IDLE;
            s_d.tx_st = AST_ST_STOP;
          end
        end
      end
      AST_ST_STOP: begin
        if (tick16) begin
          s_d.tx_ph = s_q.tx_ph + 4'h1;
          if (s_q.tx_ph == AST_OVS_LAST) begin
            s_d.tx_st = AST_ST_IDLE;
          end
        end
      end
      default: begin
        s_d.tx_st = AST_ST_IDLE;
      end
    endcase
    if (!cfg.transmit_enable) begin
      s_d.tx_st = AST_ST_IDLE;
      s_d.tx_line = AST_LINE_IDLE;
    end
    // A write in the loading cycle keeps the flag set and suppresses the edge.
    if (tx_wr) begin
      s_d.tx_full = 1'b1;
      s_d.tx_hold = tx_data;
      s_d.tx_irq = 1'b0;
    end

    // Echo drives the pad from the synchronised, filtered receive level, bypassing the shifter.
    if (cfg.loopback_echo_enable) begin
      s_d.tx_pad = s_d.rx_level ^ cfg.rx_invert ^ cfg.tx_invert;
    end else begin
      s_d.tx_pad = s_d.tx_line ^ cfg.tx_invert;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.rx_sync <= {3{AST_LINE_IDLE}};
      s_q.rx_level <= AST_LINE_IDLE;
      s_q.rx_prev <= AST_LINE_IDLE;
      s_q.tx_line <= AST_LINE_IDLE;
      s_q.tx_pad <= AST_LINE_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign status.tx_holding_full = s_q.tx_full;
  assign status.tx_active = (s_q.tx_st != AST_ST_IDLE);
  assign status.rx_holding_full = s_q.rx_full;
  assign status.rx_active = (s_q.rx_st != AST_ST_IDLE);
  assign status.start_error_flag = s_q.start_err;
  assign status.parity_error_flag = s_q.par_err;
  assign status.framing_error_flag = s_q.frm_err;
  assign status.overrun_error_flag = s_q.over_err;
  assign rx_data = s_q.rx_data;
  assign tx_empty_irq = s_q.tx_irq;
  assign rx_full_irq = s_q.rx_irq;
  assign tx_pad = s_q.tx_pad;
  assign tx_pad_oe = cfg.transmit_enable || cfg.loopback_echo_enable;

  a_tx_full_set: assert property (@(posedge clk) disable iff (!rst_n)
    tx_wr |=> status.tx_holding_full)
    else $error("holding full flag missed a write");
  a_tx_irq_fall: assert property (@(posedge clk) disable iff (!rst_n)
    tx_empty_irq == $fell(status.tx_holding_full))
    else $error("transmit interrupt not tied to full falling");
  a_rx_irq_rise: assert property (@(posedge clk) disable iff (!rst_n)
    rx_full_irq == $rose(status.rx_holding_full))
    else $error("receive interrupt not tied to full rising");
  a_rx_read_clear: assert property (@(posedge clk) disable iff (!rst_n)
    rx_rd && status.rx_holding_full |=> !status.rx_holding_full)
    else $error("read did not empty receive holding");
  a_enable_gates: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg.transmit_enable && !cfg.receive_enable |=> !status.tx_active && !status.rx_active)
    else $error("disabled path still busy");
  a_overrun_set: assert property (@(posedge clk) disable iff (!rst_n)
    push && status.rx_holding_full |=> status.overrun_error_flag)
    else $error("overrun not flagged");
  a_overrun_clear: assert property (@(posedge clk) disable iff (!rst_n)
    rx_status_wr && !(push && status.rx_holding_full) |=> !status.overrun_error_flag)
    else $error("overrun flag survived a status write");
  a_echo_pad: assert property (@(posedge clk) disable iff (!rst_n)
    $past(cfg.loopback_echo_enable) |->
      tx_pad == (s_q.rx_level ^ $past(cfg.rx_invert) ^ $past(cfg.tx_invert)))
    else $error("echo pad value wrong");
  a_tx_frame_edges: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.tx_st == AST_ST_START) |-> (s_q.tx_line == AST_LINE_START) [*1] ##0
      $past(s_q.tx_st) != AST_ST_STOP)
    else $error("start bit not low");
  a_tx_load_active: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(status.tx_holding_full) && !$past(tx_wr) |-> status.tx_active)
    else $error("load without transmitter busy");
endmodule : ast_core
`default_nettype wire

// ===== ast_pair_buf.sv
`timescale 1ns/1ns
`default_nettype none
module ast_pair_buf
  import ast_pkg::*;
#(
  parameter int unsigned WIDTH = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } ast_buf_state_type;

  ast_buf_state_type s_q;
  ast_buf_state_type s_d;
  logic put;
  logic get;

  assign in_ready = (s_q.cnt != 2'h2);
  assign out_valid = (s_q.cnt != 2'h0);
  assign out_data = s_q.mem[s_q.rp];
  assign put = in_valid && in_ready;
  assign get = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (put) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = ~s_q.wp;
    end
    if (get) begin
      s_d.rp = ~s_q.rp;
    end
    s_d.cnt = s_q.cnt + {1'b0, put} - {1'b0, get};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : ast_pair_buf
`default_nettype wire

// ===== ast_pkg.sv
package ast_pkg;
  localparam logic [3:0] AST_OVS_LAST = 4'hF;
  localparam logic [3:0] AST_MID_LAST = 4'h7;
  localparam logic [2:0] AST_LAST_BIT_8 = 3'h7;
  localparam logic [2:0] AST_LAST_BIT_7 = 3'h6;
  localparam logic [2:0] AST_RC_SEL_MAX = 3'h4;
  localparam logic [2:0] AST_BAUD_MAX = 3'h7;
  localparam logic AST_LINE_IDLE = 1'b1;
  localparam logic AST_LINE_START = 1'b0;
  localparam logic AST_PAR_EVEN = 1'b1;
  localparam logic AST_WL_8BIT = 1'b1;
  localparam int unsigned AST_DIV_W = 11;

  typedef enum logic [2:0] {
    AST_ST_IDLE = 3'h0,
    AST_ST_START = 3'h1,
    AST_ST_DATA = 3'h2,
    AST_ST_PARITY = 3'h3,
    AST_ST_STOP = 3'h4
  } ast_state_type;

  typedef struct packed {
    logic clock_source_select;
    logic [2:0] rc_prescaler_select;
    logic parity_odd_even;
    logic parity_enable;
    logic word_length_select;
    logic loopback_echo_enable;
    logic receive_enable;
    logic transmit_enable;
    logic rx_invert;
    logic tx_invert;
    logic [2:0] baud_select;
  } ast_cfg_type;

  typedef struct packed {
    logic tx_holding_full;
    logic tx_active;
    logic rx_holding_full;
    logic rx_active;
    logic start_error_flag;
    logic parity_error_flag;
    logic framing_error_flag;
    logic overrun_error_flag;
  } ast_status_type;

  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
    logic frame_err;
  } ast_rx_word_type;

  typedef struct packed {
    logic [2:0] rx_sync;
    logic rx_level;
    logic rx_prev;
    logic [2:0] xt_sync;
    logic xt_level;
    logic [2:0] rc_sync;
    logic rc_level;
    ast_state_type rx_st;
    logic [3:0] rx_ph;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_par;
    logic rx_par_bad;
    logic start_err;
    logic over_err;
    logic rx_full;
    logic [7:0] rx_data;
    logic par_err;
    logic frm_err;
    ast_state_type tx_st;
    logic [3:0] tx_ph;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_par;
    logic tx_full;
    logic [7:0] tx_hold;
    logic tx_line;
    logic tx_pad;
    logic tx_irq;
    logic rx_irq;
  } ast_core_state_type;
endpackage : ast_pkg

// ===== ast_remote.sv
`timescale 1ns/1ns
`default_nettype none
module ast_remote #(
  parameter int BIT = 64
) (
  input wire logic clk,
  output logic line_out,
  input wire logic line_in
);
  initial line_out = 1'b1;

  // Fault codes: 1 wrong parity, 2 missing stop, 3 start glitch too short to be a start.
  task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic pev,
                      input int flt);
    logic q[$];
    logic [7:0] m;
    m = (nb == 8) ? 8'hFF : 8'h7F;
    if (flt == 3) begin
      @(negedge clk) line_out <= 1'b0;
      repeat (4) @(negedge clk);
      line_out <= 1'b1;
      repeat (3 * BIT) @(negedge clk);
    end else begin
      q.push_back(1'b0);
      for (int i = 0; i < nb; i++) q.push_back(d[i]);
      if (pe) q.push_back(^(d & m) ^ !pev ^ (flt == 1));
      q.push_back(flt != 2);
      q.push_back(1'b1);
      foreach (q[i]) begin
        @(negedge clk) line_out <= q[i];
        repeat (BIT - 1) @(negedge clk);
      end
    end
  endtask : send

  // Samples at mid-bit on the falling clock edge, where the registered pad has settled.
  task automatic recv(input int nb, input logic pe, output logic [7:0] d, output logic p,
                      output logic s);
    int t;
    d = 8'h00;
    p = 1'b0;
    t = 0;
    while (line_in !== 1'b0 && t < 5000) begin
      @(negedge clk);
      t++;
    end
    repeat (BIT / 2) @(negedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT) @(negedge clk);
      d[i] = line_in;
    end
    if (pe) begin
      repeat (BIT) @(negedge clk);
      p = line_in;
    end
    repeat (BIT) @(negedge clk);
    s = line_in;
  endtask : recv
endmodule : ast_remote
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import ast_pkg::*;
;
  logic clk, rst_n, xtal_clk_in, rc_clk_in, tx_wr, rx_rd, rx_status_wr, rx_pad;
  logic tx_empty_irq, rx_full_irq, tx_pad, tx_pad_oe;
  logic [7:0] tx_data, rx_data;
  ast_cfg_type cfg;
  ast_status_type status;
  int miscompares, compares, n_txi, n_rxi;

  ast_core ast_core_i (.clk(clk), .rst_n(rst_n), .cfg(cfg), .xtal_clk_in(xtal_clk_in),
    .rc_clk_in(rc_clk_in), .tx_wr(tx_wr), .tx_data(tx_data), .rx_rd(rx_rd),
    .rx_status_wr(rx_status_wr), .status(status), .rx_data(rx_data),
    .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq), .rx_pad(rx_pad),
    .tx_pad(tx_pad), .tx_pad_oe(tx_pad_oe));
  ast_remote #(.BIT(64)) ast_remote_i (.clk(clk), .line_out(rx_pad), .line_in(tx_pad));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Both oscillators toggle on falling clock edges; the RC one runs at a quarter of clk.
  initial begin
    rc_clk_in = 1'b0;
    forever #100 rc_clk_in = ~rc_clk_in;
  end
  initial begin
    xtal_clk_in = 1'b0;
    forever #200 xtal_clk_in = ~xtal_clk_in;
  end
  always @(posedge clk) begin
    n_txi <= n_txi + (tx_empty_irq === 1'b1);
    n_rxi <= n_rxi + (rx_full_irq === 1'b1);
  end

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic set(input ast_cfg_type c);
    @(negedge clk);
    cfg = c;
  endtask : set

  task automatic rst_pulse;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask : rst_pulse

  task automatic wr_tx(input logic [7:0] d);
    @(negedge clk);
    tx_data = d;
    tx_wr = 1'b1;
    @(negedge clk);
    tx_wr = 1'b0;
    chk(status.tx_holding_full, 1'b1);
  endtask : wr_tx

  task automatic rd_rx(input logic [7:0] exp);
    @(negedge clk);
    chk(rx_data, exp);
    rx_rd = 1'b1;
    @(negedge clk);
    rx_rd = 1'b0;
    chk(status.rx_holding_full, 1'b0);
    repeat (3) @(negedge clk);
  endtask : rd_rx

  task automatic wait_pad(input logic v);
    int t;
    t = 0;
    while (tx_pad !== v && t < 20000) begin
      @(negedge clk);
      t++;
    end
  endtask : wait_pad

  // Resetting between settings cuts the frame short, so only three bits are spent per rate.
  task automatic bit_time(input ast_cfg_type c, input int bc);
    int n;
    set(c);
    rst_pulse();
    chk({status, tx_pad}, 9'h001);
    wr_tx(8'h05);
    wait_pad(1'b0);
    wait_pad(1'b1);
    wait_pad(1'b0);
    n = 0;
    while (tx_pad === 1'b0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk(n[15:0], bc[15:0]);
  endtask : bit_time

  initial begin
    ast_cfg_type c;
    logic [7:0] d;
    logic p, s;
    int k, j, e;
    rst_n = 1'b0;
    tx_wr = 1'b0;
    rx_rd = 1'b0;
    rx_status_wr = 1'b0;
    tx_data = 8'h00;
    c = '0;
    c.baud_select = 3'h7;
    c.transmit_enable = 1'b1;
    c.receive_enable = 1'b1;
    c.word_length_select = 1'b1;
    c.parity_enable = 1'b1;
    c.parity_odd_even = 1'b1;
    cfg = c;
    rst_pulse();
    chk({status, rx_data, tx_pad}, 17'h00001);
    j = n_txi;
    wr_tx(8'hA5);
    ast_remote_i.recv(8, 1'b1, d, p, s);
    chk({d, p, s}, {8'hA5, 1'b0, 1'b1});
    chk(status.tx_active, 1'b1);
    chk(16'(n_txi - j), 16'h0001);
    repeat (64) @(negedge clk);
    chk(status.tx_active, 1'b0);
    c.word_length_select = 1'b0;
    c.parity_odd_even = 1'b0;
    set(c);
    wr_tx(8'hC3);
    j = 0;
    while (status.tx_holding_full !== 1'b0 && j < 2000) begin
      @(negedge clk);
      j++;
    end
    wr_tx(8'h5A);
    ast_remote_i.recv(7, 1'b1, d, p, s);
    chk({d, p, s}, {8'h43, 1'b0, 1'b1});
    ast_remote_i.recv(7, 1'b1, d, p, s);
    chk({d, p, s}, {8'h5A, 1'b1, 1'b1});
    repeat (64) @(negedge clk);
    c.transmit_enable = 1'b0;
    set(c);
    wr_tx(8'h3D);
    repeat (200) @(negedge clk);
    chk({status.tx_holding_full, status.tx_active, tx_pad_oe}, 3'b100);
    c.parity_enable = 1'b0;
    c.transmit_enable = 1'b1;
    set(c);
    ast_remote_i.recv(7, 1'b0, d, p, s);
    chk({d, p, s}, {8'h3D, 1'b0, 1'b1});
    $display("test transmit done");
    repeat (64) @(negedge clk);
    c.word_length_select = 1'b1;
    c.parity_odd_even = 1'b1;
    c.parity_enable = 1'b1;
    set(c);
    j = n_rxi;
    ast_remote_i.send(8'hA5, 8, 1'b1, 1'b1, 0);
    chk(status, 8'h20);
    chk(16'(n_rxi - j), 16'h0001);
    rd_rx(8'hA5);
    for (k = 1; k < 4; k++) begin
      ast_remote_i.send(8'h3C, 8, 1'b1, 1'b1, k);
      chk(status, k == 1 ? 8'h24 : k == 2 ? 8'h22 : 8'h0A);
      if (k < 3) rd_rx(8'h3C);
    end
    // Holding plus two buffered words survive; the fourth has nowhere to go.
    for (k = 0; k < 4; k++) ast_remote_i.send(8'(8'h11 * (k + 1)), 8, 1'b1, 1'b1, 0);
    chk(status, 8'h21);
    for (k = 0; k < 3; k++) rd_rx(8'(8'h11 * (k + 1)));
    chk(status, 8'h01);
    @(negedge clk);
    rx_status_wr = 1'b1;
    @(negedge clk);
    rx_status_wr = 1'b0;
    chk(status, 8'h00);
    c.word_length_select = 1'b0;
    c.parity_enable = 1'b0;
    set(c);
    ast_remote_i.send(8'hD5, 7, 1'b0, 1'b0, 0);
    chk(status, 8'h20);
    rd_rx(8'h55);
    c.receive_enable = 1'b0;
    set(c);
    ast_remote_i.send(8'h77, 8, 1'b1, 1'b1, 0);
    chk(status, 8'h00);
    $display("test receive done");
    c.loopback_echo_enable = 1'b1;
    c.transmit_enable = 1'b0;
    for (k = 0; k < 8; k++) begin
      c.rx_invert = k[2];
      c.tx_invert = k[1];
      set(c);
      ast_remote_i.line_out = k[0];
      repeat (6) @(negedge clk);
      chk({tx_pad_oe, tx_pad}, {1'b1, k[0] ^ k[1] ^ k[2]});
    end
    ast_remote_i.line_out = 1'b1;
    c.loopback_echo_enable = 1'b0;
    c.transmit_enable = 1'b1;
    c.rx_invert = 1'b0;
    set(c);
    repeat (4) @(negedge clk);
    chk(tx_pad, 1'b0);
    $display("test echo done");
    c = '0;
    c.transmit_enable = 1'b1;
    c.word_length_select = 1'b1;
    for (k = 0; k < 13; k++) begin
      c.baud_select = k < 7 ? 3'(k) : k == 11 ? 3'h3 : 3'h7;
      c.rc_prescaler_select = k < 7 ? 3'h0 : k == 12 ? 3'h5 : 3'(k - 6);
      c.clock_source_select = (k == 11);
      e = k < 7 ? 64 << (7 - k) : k == 11 ? 2048 : k == 12 ? 1024 : 64 << (k - 6);
      bit_time(c, e);
    end
    $display("test rates done");
    print_verdict();
  end

  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
